// file: hw/ram_block_pkg.sv
// Constants, field layouts and types shared by the 32 x 4 memory block.
// Assumes one clock domain; every count and offset used elsewhere lives here.
package ram_block_pkg;

    // Array geometry
    localparam int WORDS = 32;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 4;

    // Register port geometry
    localparam int BUS_AW = 8;
    localparam int BUS_DW = 32;

    // Register offsets (byte addresses)
    localparam logic [7:0] CFG_OFFSET = 8'h00;
    localparam logic [7:0] CLEAR_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;

    // Configuration register fields
    localparam int CFG_SYNC_BIT = 0;
    localparam int CFG_CLKSEL_LSB = 1;
    localparam int CFG_SINGLE_BIT = 3;

    // Status register fields
    localparam int ST_SCLK_BIT = 0;
    localparam int ST_SINGLE_BIT = 1;
    localparam int ST_CONFIG_BIT = 2;
    localparam int ST_SYNC_BIT = 3;
    localparam int ST_WADDR_LSB = 8;
    localparam int ST_WDATA_LSB = 16;

    // Sector clock source
    typedef enum logic [1:0] {
        SCLK_ZERO = 2'b00,
        SCLK_TRUE = 2'b01,
        SCLK_INVERT = 2'b10
    } sclk_sel_type;

    // Write timing mode
    typedef enum logic {
        WR_ASYNC = 1'b0,
        WR_SYNC = 1'b1
    } wr_mode_type;

    // Reset values
    localparam wr_mode_type MODE_RESET = WR_ASYNC;
    localparam sclk_sel_type SCLK_RESET = SCLK_ZERO;
    localparam logic SINGLE_RESET = 1'b0;

    // Sector clock from column clock; code 11 parks the clock low
    function automatic logic sector_clock(input logic [1:0] sel, input logic col);
        logic res;
        res = 1'b0;
        if (sel == SCLK_TRUE)
            res = col;
        else if (sel == SCLK_INVERT)
            res = ~col;
        return res;
    endfunction

endpackage

// file: hw/ram_write_if.sv
// Write path between the front-end latches, the control logic and the array.
// Assumes all members are sampled on the one block clock.
`timescale 1ns/10ps
interface ram_write_if;
    import ram_block_pkg::*;

    logic [ADDR_W-1:0] addr; // Latched write address
    logic we_n; // Latched write enable, low writes
    logic [DATA_W-1:0] data; // Latched write data
    logic store_load; // Storage load control
    logic clear; // Whole-array clear

    modport front (output addr, output we_n, output data);
    modport store (input addr, input we_n, input data, input store_load, input clear);
endinterface

// file: hw/ram_front_latch.sv
// Front-end latch bank for write address, write enable and write data.
// Assumes load_i is a level from the top; the latch is modelled as pass-or-hold.
`timescale 1ns/10ps
module ram_front_latch
(
    input wire logic mclk_i, // Block clock
    input wire logic resetn_i, // Synchronous reset, active low
    input wire logic load_i, // Load control, high passes
    input wire logic [ram_block_pkg::ADDR_W-1:0] addr_i, // Write address in
    input wire logic we_n_i, // Write enable in, active low
    input wire logic [ram_block_pkg::DATA_W-1:0] data_i, // Write data in
    ram_write_if.front wr // Latched write path out
);
    import ram_block_pkg::*;

    logic [ADDR_W-1:0] addr_q;
    logic we_n_q;
    logic [DATA_W-1:0] data_q;

    // Held copy follows the inputs while open
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            addr_q <= '0;
            we_n_q <= 1'b1;
            data_q <= '0;
        end
        else if (load_i)
        begin
            addr_q <= addr_i;
            we_n_q <= we_n_i;
            data_q <= data_i;
        end
    end

    // Transparent when open, so async mode adds no cycle of delay
    assign wr.addr = load_i ? addr_i : addr_q;
    assign wr.we_n = load_i ? we_n_i : we_n_q;
    assign wr.data = load_i ? data_i : data_q;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);

    a_latch_passes: assert property (load_i |-> wr.addr == addr_i && wr.data == data_i && wr.we_n == we_n_i)
        else $error("front latch not transparent while load is high");
    a_latch_holds: assert property (!load_i ##1 !load_i |-> $stable(wr.addr) && $stable(wr.data) && $stable(wr.we_n))
        else $error("front latch changed while load is low");

endmodule

// file: hw/ram_storage.sv
// The 32 x 4 storage array: gated word writes, one-cycle clear, async read.
// Assumes the write path is driven by the front latches and the top control.
`timescale 1ns/10ps
module ram_storage
(
    input wire logic mclk_i, // Block clock
    input wire logic resetn_i, // Synchronous reset, active low
    ram_write_if.store wr, // Latched write path in
    input wire logic [ram_block_pkg::ADDR_W-1:0] rd_addr_i, // Read address
    output logic [ram_block_pkg::DATA_W-1:0] rd_data_o // Read data, combinational
);
    import ram_block_pkg::*;

    // Contents are not reset; only the clear empties the array
    logic [DATA_W-1:0] mem_q [WORDS];
    logic all_zero;

    // Clear beats a write in the same cycle
    always_ff @(posedge mclk_i)
    begin
        if (wr.clear)
        begin
            for (int i = 0; i < WORDS; i++)
                mem_q[i] <= '0;
        end
        else if (wr.store_load && !wr.we_n)
            mem_q[wr.addr] <= wr.data;
    end

    // Read never waits on the write side
    assign rd_data_o = mem_q[rd_addr_i];

    // Helper for the clear check
    always_comb
    begin
        all_zero = 1'b1;
        for (int i = 0; i < WORDS; i++)
            if (mem_q[i] != '0)
                all_zero = 1'b0;
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_write;
        wr.store_load && !wr.we_n && !wr.clear;
    endsequence

    sequence s_idle_then_same_addr;
        ((wr.we_n || !wr.store_load) && !wr.clear) ##1 $stable(rd_addr_i);
    endsequence

    a_write_lands: assert property (s_write ##1 rd_addr_i == $past(wr.addr) |-> rd_data_o == $past(wr.data))
        else $error("written word does not read back");
    a_word_holds: assert property (s_idle_then_same_addr |-> $stable(rd_data_o))
        else $error("stored word changed without a write");
    a_clear_empties: assert property (wr.clear |=> all_zero)
        else $error("array not all zero after clear");

endmodule

// file: hw/dual_port_ram_block_32x4.sv
// Top of the 32 x 4 memory block: mode control, sector clock, ports, registers.
// Assumes user logic drives all pins synchronously to mclk_i, and the column
// clock arrives as a sampled level; the testbench resolves the shared data pin.
`timescale 1ns/10ps
module dual_port_ram_block_32x4
(
    input wire logic mclk_i, // 40 MHz block clock
    input wire logic resetn_i, // Synchronous reset, active low
    input wire logic column_clock_i, // Neighbouring column clock, sampled level
    input wire logic configuring_i, // High while the device is being configured
    input wire logic right_most_i, // High when placed in the right-most column
    input wire logic [ram_block_pkg::BUS_AW-1:0] reg_addr_i, // Register byte address
    input wire logic [ram_block_pkg::BUS_DW-1:0] reg_wdata_i, // Register write data
    input wire logic reg_write_i, // Register write strobe
    input wire logic reg_read_i, // Register read strobe
    output logic [ram_block_pkg::BUS_DW-1:0] reg_rdata_o, // Register read data
    input wire logic [ram_block_pkg::ADDR_W-1:0] write_addr_i, // Write address
    input wire logic write_enable_n_i, // Write enable, active low
    input wire logic [ram_block_pkg::DATA_W-1:0] write_data_i, // Data pin, input side
    output logic [ram_block_pkg::DATA_W-1:0] write_data_o, // Data pin, output side
    output logic write_data_oe_o, // Data pin drive enable
    input wire logic [ram_block_pkg::ADDR_W-1:0] read_addr_i, // Read address
    input wire logic output_enable_n_i, // Output enable, active low
    output logic [ram_block_pkg::DATA_W-1:0] read_data_o, // Read data pin, output side
    output logic read_data_oe_o // Read data pin drive enable
);
    import ram_block_pkg::*;

    wr_mode_type mode_q;
    sclk_sel_type sclk_sel_q;
    logic single_cfg_q;
    logic sclk;
    logic sclk_prev_q;
    logic sclk_rise;
    logic front_load;
    logic single_eff;
    logic clear_hit;
    logic [ADDR_W-1:0] rd_addr;
    logic [DATA_W-1:0] st_rd_data;
    logic [ADDR_W-1:0] last_waddr_q;
    logic [DATA_W-1:0] last_wdata_q;
    logic [BUS_DW-1:0] status_word;
    logic [BUS_DW-1:0] reg_rdata_q;

    ram_write_if wif();

    // Configuration register; reset parks the sector clock to save power
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            mode_q <= MODE_RESET;
            sclk_sel_q <= SCLK_RESET;
            single_cfg_q <= SINGLE_RESET;
        end
        else if (reg_write_i && reg_addr_i == CFG_OFFSET)
        begin
            mode_q <= wr_mode_type'(reg_wdata_i[CFG_SYNC_BIT]);
            sclk_sel_q <= sclk_sel_type'(reg_wdata_i[CFG_CLKSEL_LSB +: 2]);
            single_cfg_q <= reg_wdata_i[CFG_SINGLE_BIT];
        end
    end

    // Sector clock taken from the adjacent column clock
    assign sclk = sector_clock(sclk_sel_q, column_clock_i);

    // Previous sector clock level for edge detection
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
            sclk_prev_q <= 1'b0;
        else
            sclk_prev_q <= sclk;
    end

    assign sclk_rise = sclk && !sclk_prev_q;

    // Both loads held open in async mode; in sync mode front open while clock low, array takes the rise.
    // Opposite phases make the pair an edge-triggered stage in sync mode.
    always_comb
    begin
        front_load = 1'b1;
        wif.store_load = 1'b1;
        if (mode_q == WR_SYNC)
        begin
            front_load = ~sclk;
            wif.store_load = sclk_rise;
        end
    end

    // Clear only counts while configuring
    assign clear_hit = reg_write_i && reg_addr_i == CLEAR_OFFSET && configuring_i;
    assign wif.clear = clear_hit;

    // Right-most placement cannot be dual-ported
    assign single_eff = single_cfg_q || right_most_i;

    // Read address tie-off in single-port use
    assign rd_addr = single_eff ? write_addr_i : read_addr_i;

    // Write enable from user logic passes through the front latches
    ram_front_latch u_front
    (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .load_i(front_load),
        .addr_i(write_addr_i),
        .we_n_i(write_enable_n_i),
        .data_i(write_data_i),
        .wr(wif.front)
    );

    ram_storage u_store
    (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .wr(wif.store),
        .rd_addr_i(rd_addr),
        .rd_data_o(st_rd_data)
    );

    // Output drivers; read data is combinational so reads stay asynchronous
    always_comb
    begin
        read_data_o = '0;
        read_data_oe_o = 1'b0;
        write_data_o = '0;
        write_data_oe_o = 1'b0;
        if (!output_enable_n_i)
        begin
            if (single_eff)
            begin
                write_data_o = st_rd_data;
                write_data_oe_o = 1'b1;
            end
            else
            begin
                read_data_o = st_rd_data;
                read_data_oe_o = 1'b1;
            end
        end
    end

    // Last word written, for software to observe
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            last_waddr_q <= '0;
            last_wdata_q <= '0;
        end
        else if (wif.store_load && !wif.we_n && !wif.clear)
        begin
            last_waddr_q <= wif.addr;
            last_wdata_q <= wif.data;
        end
    end

    // Status word assembly; unused bits read as zero
    always_comb
    begin
        status_word = '0;
        status_word[ST_SCLK_BIT] = sclk;
        status_word[ST_SINGLE_BIT] = single_eff;
        status_word[ST_CONFIG_BIT] = configuring_i;
        status_word[ST_SYNC_BIT] = mode_q;
        status_word[ST_WADDR_LSB +: ADDR_W] = last_waddr_q;
        status_word[ST_WDATA_LSB +: DATA_W] = last_wdata_q;
    end

    // Read data valid only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
            reg_rdata_q <= '0;
        else if (!reg_read_i)
            reg_rdata_q <= '0;
        else if (reg_addr_i == CFG_OFFSET)
        begin
            reg_rdata_q <= '0;
            reg_rdata_q[CFG_SYNC_BIT] <= mode_q;
            reg_rdata_q[CFG_CLKSEL_LSB +: 2] <= sclk_sel_q;
            reg_rdata_q[CFG_SINGLE_BIT] <= single_cfg_q;
        end
        else if (reg_addr_i == STATUS_OFFSET)
            reg_rdata_q <= status_word;
        else
            reg_rdata_q <= '0;
    end

    assign reg_rdata_o = reg_rdata_q;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_sync_rise;
        mode_q == WR_SYNC && sclk && !sclk_prev_q;
    endsequence

    sequence s_sync_no_rise;
        mode_q == WR_SYNC && !(sclk && !sclk_prev_q);
    endsequence

    a_read_follows: assert property (!single_eff && !output_enable_n_i |-> read_data_o == st_rd_data)
        else $error("read data does not follow the array");
    a_oe_gates: assert property (output_enable_n_i |-> !read_data_oe_o && !write_data_oe_o)
        else $error("data driven while output enable is high");
    a_single_shared: assert property (single_eff |-> rd_addr == write_addr_i && !read_data_oe_o)
        else $error("single-port does not share the write address");
    a_right_most: assert property (right_most_i ##1 right_most_i |-> single_eff && !read_data_oe_o)
        else $error("right-most block acting dual-ported");
    a_sync_edge_write: assert property (s_sync_rise |-> wif.store_load && !front_load)
        else $error("sync write missed a rising edge");
    a_sync_no_edge: assert property (s_sync_no_rise |-> !wif.store_load)
        else $error("sync write outside a rising edge");
    a_async_open: assert property (mode_q == WR_ASYNC |-> wif.store_load && front_load)
        else $error("async mode latches not transparent");
    a_clock_zero: assert property (sclk_sel_q == SCLK_ZERO |-> !sclk ##1 (sclk_sel_q != SCLK_ZERO || !sclk_prev_q))
        else $error("parked sector clock not low");
    a_clock_invert: assert property (sclk_sel_q == SCLK_INVERT |-> sclk == !column_clock_i)
        else $error("inverted sector clock wrong");
    a_clear_config: assert property (reg_write_i && reg_addr_i == CLEAR_OFFSET |-> wif.clear == configuring_i)
        else $error("clear not gated by configuration");
    a_rdata_window: assert property (!reg_read_i |=> reg_rdata_o == '0)
        else $error("register read data outside its cycle");

endmodule

// file: tb/fabric_user_model.sv
// Model of the user fabric on the shared data pin of the memory block.
// Assumes fabric and block share mclk_i; a released pin shows noise, not a stale copy.
`timescale 1ns/10ps
module fabric_user_model
(
    input wire logic mclk_i, // Block clock
    input wire logic [ram_block_pkg::DATA_W-1:0] user_data_i, // Data the fabric offers
    input wire logic user_drive_i, // Fabric drives the pin
    input wire logic [ram_block_pkg::DATA_W-1:0] dev_data_i, // Data the block offers
    input wire logic dev_oe_i, // Block drives the pin
    output logic [ram_block_pkg::DATA_W-1:0] pin_o, // Resolved pin level
    output logic clash_o // Both sides drive at once
);
    import ram_block_pkg::*;

    logic [DATA_W-1:0] last_q;

    // Pin resolution; no pull, so an idle pin toggles every cycle
    always_comb
    begin
        if (dev_oe_i)
            pin_o = dev_data_i;
        else if (user_drive_i)
            pin_o = user_data_i;
        else
            pin_o = ~last_q;
    end

    // Remember the level so the idle pattern keeps moving
    always_ff @(posedge mclk_i)
    begin
        last_q <= pin_o;
    end

    assign clash_o = dev_oe_i & user_drive_i;
endmodule

// file: tb/dual_port_ram_block_32x4_test.sv
// Self-checking bench for the 32 x 4 memory block.
// Assumes the fabric model resolves the shared data pin; all stimulus on rising edges.
`timescale 1ns/10ps
module dual_port_ram_block_32x4_test;
    import ram_block_pkg::*;

    logic mclk_i = 1'b0;
    logic resetn, col, configuring, right_most, reg_write, reg_read, wen_n, oen_n, user_drive;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, v;
    logic [4:0] waddr, raddr;
    logic [3:0] wdata, pin, dev_data;
    logic [31:0] rdata;
    logic [3:0] rd_data;
    logic dev_oe, rd_oe, clash;
    int fail_count = 0;
    int checked = 0;
    int sel;

    // 40 MHz clock
    always #12.5 mclk_i = ~mclk_i;

    dual_port_ram_block_32x4 i_dual_port_ram_block_32x4 (.mclk_i(mclk_i), .resetn_i(resetn),
        .column_clock_i(col), .configuring_i(configuring), .right_most_i(right_most),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_write_i(reg_write), .reg_read_i(reg_read),
        .reg_rdata_o(rdata), .write_addr_i(waddr), .write_enable_n_i(wen_n), .write_data_i(pin),
        .write_data_o(dev_data), .write_data_oe_o(dev_oe), .read_addr_i(raddr),
        .output_enable_n_i(oen_n), .read_data_o(rd_data), .read_data_oe_o(rd_oe));

    fabric_user_model i_fabric_user_model (.mclk_i(mclk_i), .user_data_i(wdata),
        .user_drive_i(user_drive), .dev_data_i(dev_data), .dev_oe_i(dev_oe), .pin_o(pin), .clash_o(clash));

    // Distinct patterns for low and high halves catch a dropped address bit
    function automatic logic [3:0] pat(input logic [4:0] a);
        return a[3:0] ^ (a[4] ? 4'hF : 4'h5);
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        $display("checked %0d, fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Register port: one-cycle strobes, read data in the following cycle only
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge mclk_i);
        reg_write <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic reg_rd(input logic [7:0] a);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge mclk_i);
        reg_read <= 1'b0;
        @(negedge mclk_i);
        v = rdata;
        @(posedge mclk_i);
    endtask

    // Read port is combinational; sample mid-cycle
    task automatic rd_chk(input logic [4:0] a, input logic [3:0] exp);
        raddr <= a;
        @(negedge mclk_i);
        chk(32'(rd_data), 32'(exp));
        @(posedge mclk_i);
    endtask

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge mclk_i);
        fail_count++;
        finish_test();
    end

    // Pin contention means the block drove while the fabric did
    always @(negedge mclk_i)
    begin
        if (clash !== 1'b0)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t data pin driven from both sides", $time);
        end
    end

    initial
    begin
        resetn = 1'b0; col = 1'b0; configuring = 1'b1; right_most = 1'b0; reg_addr = 8'h00;
        reg_wdata = 32'h0; reg_write = 1'b0; reg_read = 1'b0; waddr = 5'h00; wen_n = 1'b1;
        wdata = 4'h0; raddr = 5'h00; oen_n = 1'b1; user_drive = 1'b1;
        repeat (6) @(posedge mclk_i);
        resetn <= 1'b1;
        // Clear first: the array powers up unknown, so the read pin stays off until then
        reg_wr(CLEAR_OFFSET, 32'hA5);
        oen_n <= 1'b0;
        // Reset values, unmapped offset, clear during configuration
        reg_rd(CFG_OFFSET); chk(v, 32'h0);
        reg_rd(STATUS_OFFSET); chk(v, 32'h4);
        reg_rd(8'h0C); chk(v, 32'h0);
        for (int a = 0; a < WORDS; a++)
            rd_chk(5'(a), 4'h0);
        configuring <= 1'b0;
        // Back-to-back async writes; the read port follows the previous word meanwhile
        for (int a = 0; a < WORDS; a++)
        begin
            waddr <= 5'(a);
            wdata <= pat(5'(a));
            wen_n <= 1'b0;
            raddr <= 5'(a - 1);
            @(negedge mclk_i);
            if (a > 0)
                chk(32'(rd_data), 32'(pat(5'(a - 1))));
            @(posedge mclk_i);
        end
        wen_n <= 1'b1;
        for (int a = 0; a < WORDS; a++)
            rd_chk(5'(a), pat(5'(a)));
        chk(32'(rd_oe), 32'h1);
        reg_rd(STATUS_OFFSET); chk(v, {12'h0, pat(5'd31), 3'b0, 5'd31, 8'h00});
        reg_wr(CLEAR_OFFSET, 32'h1);
        // Word 30 holds a non-zero pattern, so a wrongly taken clear shows
        rd_chk(5'd30, pat(5'd30));
        waddr <= 5'd7;
        wdata <= 4'h0;
        rd_chk(5'd7, pat(5'd7));
        // Output enable off releases the read pin
        oen_n <= 1'b1;
        @(negedge mclk_i);
        chk(32'({rd_oe, rd_data}), 32'h0);
        @(posedge mclk_i);
        oen_n <= 1'b0;
        // Sector clock codes in sync mode: a write only on a rising sector clock
        for (int i = 0; i < 3; i++)
        begin
            sel = (i == 0) ? 1 : (i == 1) ? 2 : 0;
            col <= (sel == 2);
            reg_wr(CFG_OFFSET, 32'(1 + 2 * sel));
            waddr <= 5'(8 + i);
            wdata <= 4'h6;
            wen_n <= 1'b0;
            @(posedge mclk_i);
            col <= (sel != 2);
            @(posedge mclk_i);
            waddr <= 5'(14 + i);
            wdata <= 4'h1;
            @(posedge mclk_i);
            wen_n <= 1'b1;
            reg_rd(STATUS_OFFSET); chk(32'({v[3], v[0]}), 32'({1'b1, sel != 0}));
            rd_chk(5'(8 + i), (sel != 0) ? 4'h6 : pat(5'(8 + i)));
            rd_chk(5'(14 + i), pat(5'(14 + i)));
        end
        // Single-port by configuration, then by right-most placement
        for (int sp = 0; sp < 2; sp++)
        begin
            // Fabric lets go of the pin before the block may start driving it
            right_most <= (sp == 1);
            user_drive <= 1'b0;
            reg_wr(CFG_OFFSET, (sp == 0) ? 32'h8 : 32'h0);
            waddr <= 5'd8;
            raddr <= 5'd0;
            @(negedge mclk_i);
            chk(32'({dev_oe, dev_data}), 32'h16);
            chk(32'(rd_oe), 32'h0);
            @(posedge mclk_i);
            reg_rd(STATUS_OFFSET); chk(32'(v[1]), 32'h1);
            oen_n <= 1'b1;
            user_drive <= 1'b1;
            waddr <= 5'd13;
            wdata <= 4'(3 + sp);
            wen_n <= 1'b0;
            @(posedge mclk_i);
            wen_n <= 1'b1;
            user_drive <= 1'b0;
            oen_n <= 1'b0;
            @(negedge mclk_i);
            chk(32'(pin), 32'(3 + sp));
            @(posedge mclk_i);
        end
        finish_test();
    end
endmodule
